// ---- hw/led_driver_fault_monitor_ctrl.sv ----
// digital supervision of a six-string backlight driver with apb registers
// Notes on behaviour
// - dither switching frequency pseudorandomly within 97-103%, or 94-106% when wide.
// - dithering stops while the oscillator follows an external sync clock.
// - spread-disable bit set to 1 stops dithering, fixed frequency.
// - pwm dimming switches each sink between zero and full scale at duty.
// - hybrid dimming lowers current linearly to the threshold level, then pwm.
// - fault flag low on open, short, boost undervoltage or thermal shutdown.
// - short and thermal faults self release; open fault latches until power cycle.
// - shut down at 165C, resume with soft-start after 15C drop.
// - thermal shutdown sets the overtemperature status bit and pulls the flag.
// - thermal warning bit shows while junction is above 125C.
// - warning mask bit decides if the warning pulls the fault flag.
// - after soft-start open strings leave feedback and read zero current.
// - open string overvoltage switches converter off and latches the flag.
// - sinks below 300mV are left out of the minimum voltage detector.
// - outputs checked for shorts before current; shorted strings disconnected.
// - short threshold zero or low-dim mode disables short detection.
// - short scan runs periodically at 100Hz with dim input high or internal.
// - host writes convert 1; device clears it when results are updated.
// - current full scale 127.5mA; above full scale saturates to 0xff.
// - channels in low-dim mode during conversion return 0x00.
// - conversion starts at a dimming cycle and ends under 50us later.
// - host reaches the control port as a target; host starts transfers.
// - dimming on-time under 50us enters low-dim, converter runs continuously.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module led_driver_fault_monitor_ctrl
	import led_fault_pkg::*;
#(
	parameter int unsigned DIM_PERIOD  = DIM_CYC,
	parameter int unsigned SCAN_PERIOD = SCAN_CYC,
	parameter logic [3:0]  REVISION    = 4'h1 // arbitrary value
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// analog side
	input  wire sense_type   sense,
	input  wire adc_type     adc,
	input  wire logic        dim_in,
	// drive outputs
	output logic [5:0]       sink_on,
	output logic [7:0]       current_level,
	output logic [5:0]       feedback_include,
	output logic signed [3:0] freq_trim_pct,
	output logic             converter_on,
	output logic             soft_start_req,
	output logic             conv_run,
	output logic             low_dim,
	output logic [1:0]       short_threshold_sel,
	// open-drain fault flag
	output logic             fault_flag_n_o,
	output logic             fault_flag_n_oe
);
	localparam int CONV_LIM = 1000;

	if (DIM_PERIOD > CNT_MAX || DIM_PERIOD < 2 || SCAN_PERIOD > 2 * CNT_MAX + 1
	    || SCAN_PERIOD < 2 || CONV_CYC > 1023) begin : g_check
		$error("period parameter out of range");
	end

	state_type s;
	state_type next_s;

	logic [7:0]  idx;
	logic        hit;
	logic [7:0]  rd;
	logic        wr;
	logic        ext;
	logic        hdim;
	logic [7:0]  thr;
	logic [8:0]  den;
	logic        linear;
	logic        pwm_on;
	logic        low_dim_int;
	logic        low_dim_indicator;
	logic        rise;
	logic        tick;
	logic        cycle_start;
	logic        scan;
	logic [7:0]  mod_val;

	assign idx = paddr[9:2];
	assign wr  = psel & penable & pwrite;
	assign ext = s.imode[IMODE_EXTERNAL_DIM_SELECT];
	assign hdim = s.imode[IMODE_HDIM];
	assign thr = HDIM_LEVEL[s.imode[1:0]];

	// read mux and address decode, upper address bits must be zero
	always_comb begin
		hit = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
		rd  = 8'h00;
		case (idx)
			IDX_REV:      rd = {2'h0, {2{low_dim_indicator}}, REVISION};
			IDX_FULL_SCALE_CURRENT_SEL:     rd = {s.full_scale_current_sel[7], s.conv_st != CONV_IDLE, s.full_scale_current_sel[5:0]};
			IDX_IMODE:    rd = {{4{low_dim_indicator}}, s.imode};
			IDX_SETTING:  rd = {1'b0, s.setting};
			IDX_BOOST_MONITOR:   rd = s.boost_monitor;
			IDX_OPEN:     rd = {2'h0, s.open_lat};
			IDX_SHORTLED: rd = {2'h0, s.short_lat};
			IDX_MASK:     rd = {3'h0, s.mask};
			IDX_DIAG:     rd = {3'h0, sense.boost_uv, s.ovp, 1'b0, sense.temp_warn, s.ot};
			IDX_DUTY:     rd = s.duty;
			default: begin
				if (idx >= IDX_IOUT1 && idx < IDX_IOUT1 + 8'h06) begin
					rd = s.string_current_result[3'(idx - IDX_IOUT1)];
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	// dimming decode: den is the pwm denominator, 256 plain or the level in hybrid
	always_comb begin
		linear = hdim && (s.duty >= thr);
		den = hdim ? {1'b0, thr} : 9'h100;
		pwm_on = linear ||
			(27'(s.dim_cnt) * 27'(den) < 27'(s.duty) * 27'(DIM_PERIOD));
		low_dim_int = !linear && (s.duty != 8'h00) &&
			(27'(s.duty) * 27'(DIM_PERIOD) < 27'(LOW_DIM_CYC) * 27'(den));
		low_dim_indicator = ext ? s.ext_low_dim : low_dim_int;
		rise = dim_in && !s.dim_q;
		tick = (s.scan_cnt == 18'(SCAN_PERIOD - 1));
		cycle_start = ext ? (rise || (dim_in && tick)) : (s.dim_cnt == 17'h0);
		// scan before each external pulse and periodically while held high
		scan = (s.setting[1:0] != 2'h0) && !low_dim_indicator &&
			(ext ? (rise || (dim_in && tick)) : tick);
		mod_val = s.setting[SET_SSL] ? 8'(s.lfsr % 8'd13) : 8'(s.lfsr % 8'd7);
	end

	// next state
	always_comb begin
		next_s = s;
		// free running lfsr feeds the dither, span follows the width bit
		next_s.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
		if (sense.ext_sync || s.setting[SET_SS_OFF]) begin
			next_s.trim = 4'h0;
		end else begin
			next_s.trim = 4'(mod_val) -
				(s.setting[SET_SSL] ? SPAN_WIDE : SPAN_NARROW);
		end
		// dimming counters
		next_s.dim_cnt = (s.dim_cnt == 17'(DIM_PERIOD - 1)) ? 17'h0 : s.dim_cnt + 17'h1;
		next_s.scan_cnt = tick ? 18'h0 : s.scan_cnt + 18'h1;
		next_s.dim_q = dim_in;
		// external on-time measured per pulse, held high is never low-dim
		if (dim_in) begin
			if (s.hi_cnt != 17'h1ffff) begin
				next_s.hi_cnt = s.hi_cnt + 17'h1;
			end
			if (32'(s.hi_cnt) >= LOW_DIM_CYC) begin
				next_s.ext_low_dim = 1'b0;
			end
		end else begin
			next_s.hi_cnt = 17'h0;
			if (s.dim_q) begin
				next_s.ext_low_dim = (32'(s.hi_cnt) < LOW_DIM_CYC);
			end
		end
		// short detection self releases on the next clean scan
		if (s.setting[1:0] == 2'h0) begin
			next_s.short_lat = 6'h00;
		end else if (scan) begin
			next_s.short_lat = sense.short_det & ~s.open_lat;
		end
		// open strings latch until power is cycled
		if (sense.soft_start_done) begin
			next_s.open_lat = s.open_lat | sense.open_det;
		end
		// overvoltage counts only with an open string, a plain spike is the loop's job
		if (sense.boost_ov && (sense.open_det != 6'h00)) begin
			next_s.ovp = 1'b1;
			next_s.open_lat = s.open_lat | sense.open_det;
		end
		// thermal shutdown with hysteresis comparator
		if (sense.temp_hot) begin
			next_s.ot = 1'b1;
		end else if (sense.temp_cool) begin
			next_s.ot = 1'b0;
		end
		// one-cycle pulse so the boost soft-start fires once per recovery
		next_s.restart = s.ot && !next_s.ot;
		next_s.conv_on = !next_s.ot && !next_s.ovp;
		next_s.fault = (next_s.open_lat != 6'h00) || next_s.ovp ||
			(next_s.short_lat != 6'h00) || sense.boost_uv || next_s.ot ||
			(sense.temp_warn && !s.mask[MASK_OTW]);
		// outputs, shorted and open strings never carry current
		next_s.sink_on = {6{pwm_on && next_s.conv_on}} &
			~next_s.short_lat & ~next_s.open_lat;
		// external mode follows the pin directly, hybrid never applies there
		if (ext) begin
			next_s.sink_on = {6{dim_in && next_s.conv_on}} &
				~next_s.short_lat & ~next_s.open_lat;
		end
		next_s.level = (!ext && hdim) ? (linear ? s.duty : thr) : FULL_SCALE;
		next_s.fb_include = ~next_s.open_lat & ~sense.below_300mv;
		// conversion waits for a dimming cycle start, then runs a fixed window
		case (s.conv_st)
			CONV_IDLE: begin
			end
			CONV_WAIT: begin
				if (cycle_start) begin
					next_s.conv_st = CONV_RUN;
					next_s.conv_cnt = 10'h0;
				end
			end
			CONV_RUN: begin
				next_s.conv_cnt = s.conv_cnt + 10'h1;
				if (s.conv_cnt == 10'(CONV_CYC - 1)) begin
					next_s.conv_st = CONV_IDLE;
					next_s.boost_monitor = adc.boost;
					for (int i = 0; i < 6; i++) begin
						if (low_dim_indicator || s.open_lat[i]) begin
							next_s.string_current_result[i] = 8'h00;
						end else if (adc.current[i][8]) begin
							next_s.string_current_result[i] = FULL_SCALE;
						end else begin
							next_s.string_current_result[i] = adc.current[i][7:0];
						end
					end
				end
			end
			default: begin
				next_s.conv_st = CONV_IDLE;
			end
		endcase
		// apb writes, a new convert request wins over completion
		if (wr && hit) begin
			case (idx)
				IDX_FULL_SCALE_CURRENT_SEL: begin
					next_s.full_scale_current_sel = pwdata[7:0];
					if (pwdata[FULL_SCALE_CURRENT_SEL_CONVERT]) begin
						next_s.conv_st = CONV_WAIT;
					end
				end
				IDX_IMODE:   next_s.imode = pwdata[3:0];
				IDX_SETTING: next_s.setting = pwdata[6:0];
				IDX_MASK:    next_s.mask = pwdata[4:0];
				IDX_DUTY:    next_s.duty = pwdata[7:0];
				default: begin
				end
			endcase
		end
		// read data captured in the setup phase so it is stable in access
		if (psel && !penable && !pwrite) begin
			next_s.prdata = {24'h0, rd};
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.full_scale_current_sel <= FULL_SCALE_CURRENT_SEL_RST;
			s.imode <= IMODE_RST;
			s.setting <= SETTING_RST;
			s.mask <= MASK_RST;
			s.duty <= DUTY_RST;
			s.lfsr <= LFSR_SEED;
			s.conv_st <= CONV_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// port drive
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign sink_on = s.sink_on;
	assign current_level = s.level;
	assign feedback_include = s.fb_include;
	assign freq_trim_pct = s.trim;
	assign converter_on = s.conv_on;
	assign soft_start_req = s.restart;
	assign conv_run = (s.conv_st == CONV_RUN);
	assign low_dim = low_dim_indicator;
	assign short_threshold_sel = s.setting[1:0];
	assign fault_flag_n_o = 1'b0; // open drain, only ever pulls low
	assign fault_flag_n_oe = s.fault;

	// guards, all on the bus clock and quiet during reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence conv_launch;
		$rose(s.conv_st == CONV_RUN);
	endsequence

	sequence conv_finish;
		s.conv_st != CONV_RUN && s.conv_st != CONV_WAIT;
	endsequence

	sequence conv_last;
		s.conv_st == CONV_RUN && s.conv_cnt == 10'(CONV_CYC - 1);
	endsequence

	AST_DITHER_NARROW: assert property (
		!s.setting[SET_SSL] && !s.setting[SET_SS_OFF] && !sense.ext_sync |=>
		$signed(freq_trim_pct) >= -4'sd3 && $signed(freq_trim_pct) <= 4'sd3)
		else $error("narrow dither out of range");
	AST_SYNC_STOPS: assert property (
		sense.ext_sync |=> freq_trim_pct == 4'h0)
		else $error("dither with external sync");
	AST_SS_OFF: assert property (
		s.setting[SET_SS_OFF] |=> freq_trim_pct == 4'h0)
		else $error("dither while disabled");
	AST_OPEN_HOLDS: assert property (
		s.open_lat != 6'h00 |-> fault_flag_n_oe ##1 (s.open_lat != 6'h00))
		else $error("open fault released");
	AST_THERMAL: assert property (
		sense.temp_hot |=> s.ot && fault_flag_n_oe && !converter_on)
		else $error("thermal shutdown missed");
	AST_SHORT_OFF: assert property (
		(s.sink_on & s.short_lat) == 6'h00)
		else $error("shorted string carries current");
	AST_SHORT_THRESHOLD_SEL_ZERO: assert property (
		s.setting[1:0] == 2'h0 |=> s.short_lat == 6'h00)
		else $error("short flag with detection off");
	AST_WARN_MASK: assert property (
		sense.temp_warn && !s.mask[MASK_OTW] |=> fault_flag_n_oe)
		else $error("unmasked warning not on flag");
	AST_CONV_DONE: assert property (
		conv_launch |-> ##[1:CONV_LIM] conv_finish)
		else $error("conversion overran");
	AST_LOWDIM_ZERO: assert property (
		s.conv_st == CONV_RUN && s.conv_cnt == 10'(CONV_CYC - 1) && low_dim_indicator
		|=> s.string_current_result == '0)
		else $error("low-dim channel not zero");
	AST_FB_300: assert property (
		sense.below_300mv != 6'h00 |=> (s.fb_include & $past(sense.below_300mv)) == 6'h00)
		else $error("low sink kept in feedback");

	// level, latch, soft-start, feedback and conversion end guards
	AST_PWM_FULL: assert property (
		ext || !hdim |=> current_level == FULL_SCALE)
		else $error("pwm level not full scale");
	AST_HYBRID_FLOOR: assert property (
		!ext && hdim && s.duty < thr |=> current_level == $past(thr))
		else $error("hybrid level below threshold");
	AST_OVP_LATCH: assert property (
		s.ovp |=> s.ovp && !converter_on && fault_flag_n_oe)
		else $error("overvoltage latch released");
	AST_RESTART: assert property (
		$fell(s.ot) |-> soft_start_req)
		else $error("no soft-start after thermal shutdown");
	AST_OPEN_FB: assert property (
		(feedback_include & s.open_lat) == 6'h00)
		else $error("open string kept in feedback");
	AST_SCAN_LATCH: assert property (
		scan && sense.short_det[2] && !s.open_lat[2]
		|=> s.short_lat[2] && fault_flag_n_oe)
		else $error("scan missed a short");
	AST_STRING_CURRENT_RESULT_SAT: assert property (
		conv_last ##0 (adc.current[5][8] && !low_dim_indicator && !s.open_lat[5])
		|=> s.string_current_result[5] == FULL_SCALE)
		else $error("over-range code not saturated");
	AST_CONV_CLEAR: assert property (
		conv_last ##0 !(wr && hit && idx == IDX_FULL_SCALE_CURRENT_SEL && pwdata[FULL_SCALE_CURRENT_SEL_CONVERT])
		|=> s.conv_st == CONV_IDLE && !conv_run)
		else $error("convert bit not cleared");
endmodule

// ---- include/led_fault_pkg.sv ----
// shared constants and types of the backlight supervision block
package led_fault_pkg;
	// timing
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int unsigned LOW_DIM_US    = 50;
	localparam int unsigned LOW_DIM_CYC   = LOW_DIM_US * CLK_PER_US;
	localparam int unsigned CONV_US       = 45;
	localparam int unsigned CONV_CYC      = CONV_US * CLK_PER_US;
	localparam int unsigned SCAN_HZ       = 100;
	localparam int unsigned SCAN_CYC      = CLK_HZ / SCAN_HZ;
	localparam int unsigned DIM_HZ        = 200;
	localparam int unsigned DIM_CYC       = CLK_HZ / DIM_HZ;
	localparam int unsigned CNT_MAX       = 131071;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_REV        = 8'h01;
	localparam logic [7:0] IDX_FULL_SCALE_CURRENT_SEL       = 8'h02;
	localparam logic [7:0] IDX_IMODE      = 8'h03;
	localparam logic [7:0] IDX_SETTING    = 8'h12;
	localparam logic [7:0] IDX_BOOST_MONITOR     = 8'h14;
	localparam logic [7:0] IDX_IOUT1      = 8'h15;
	localparam logic [7:0] IDX_OPEN       = 8'h1b;
	localparam logic [7:0] IDX_SHORTLED   = 8'h1d;
	localparam logic [7:0] IDX_MASK       = 8'h1e;
	localparam logic [7:0] IDX_DIAG       = 8'h1f;
	localparam logic [7:0] IDX_DUTY       = 8'h20;
	// field positions
	localparam int FULL_SCALE_CURRENT_SEL_CONVERT   = 6;
	localparam int IMODE_EXTERNAL_DIM_SELECT  = 3;
	localparam int IMODE_HDIM     = 2;
	localparam int SET_SS_OFF     = 3;
	localparam int SET_SSL        = 2;
	localparam int MASK_OTW       = 1;
	// reset values
	localparam logic [7:0] FULL_SCALE_CURRENT_SEL_RST     = 8'h00;
	localparam logic [3:0] IMODE_RST    = 4'h0;
	localparam logic [6:0] SETTING_RST  = 7'h01;
	localparam logic [4:0] MASK_RST     = 5'h00;
	localparam logic [7:0] DUTY_RST     = 8'h00;
	localparam logic [7:0] LFSR_SEED    = 8'h01;
	localparam logic [7:0] FULL_SCALE   = 8'hff;
	// hybrid crossover levels for threshold select 0..3
	localparam logic [7:0] HDIM_LEVEL [4] = '{8'h20, 8'h40, 8'h60, 8'h80};
	localparam logic [3:0] SPAN_NARROW  = 4'h3;
	localparam logic [3:0] SPAN_WIDE    = 4'h6;

	typedef enum logic [1:0] {CONV_IDLE, CONV_WAIT, CONV_RUN} conv_state_type;

	// comparator levels from the analog side
	typedef struct packed {
		logic       ext_sync;
		logic [5:0] open_det;
		logic [5:0] short_det;
		logic [5:0] below_300mv;
		logic       boost_uv;
		logic       boost_ov;
		logic       temp_hot;
		logic       temp_cool;
		logic       temp_warn;
		logic       soft_start_done;
	} sense_type;

	// raw converter codes, one lsb is full scale over 255
	typedef struct packed {
		logic [5:0][8:0] current;
		logic [7:0]      boost;
	} adc_type;

	typedef struct packed {
		logic [7:0]      full_scale_current_sel;
		logic [3:0]      imode;
		logic [6:0]      setting;
		logic [4:0]      mask;
		logic [7:0]      duty;
		logic [7:0]      boost_monitor;
		logic [5:0][7:0] string_current_result;
		logic [5:0]      open_lat;
		logic [5:0]      short_lat;
		logic            ot;
		logic            ovp;
		logic            fault;
		logic [7:0]      lfsr;
		logic [3:0]      trim;
		logic [16:0]     dim_cnt;
		logic [17:0]     scan_cnt;
		logic            dim_q;
		logic [16:0]     hi_cnt;
		logic            ext_low_dim;
		conv_state_type  conv_st;
		logic [9:0]      conv_cnt;
		logic [5:0]      sink_on;
		logic [7:0]      level;
		logic [5:0]      fb_include;
		logic            conv_on;
		logic            restart;
		logic [31:0]     prdata;
	} state_type;
endpackage

// ---- verification/apb_host_model.sv ----
// host side model: apb master that issues register cycles for the bench
`timescale 1ns/10ps
module apb_host_model (
	// clock
	input  wire logic        pclk,
	// apb request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      paddr,
	output logic [31:0]      pwdata,
	// slave answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic hung;

	// idle bus until the first transfer
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		hung = 1'b0;
	end

	// one whole transfer; the host alone starts it, and holds it until pready or for at most 16 cycles
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// a slave that never answers is reported through hung, not by hanging
		if (n >= 16) hung = 1'b1;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- verification/led_driver_fault_monitor_ctrl_test.sv ----
// self-checking bench of the backlight supervision block
`timescale 1ns/10ps
module led_driver_fault_monitor_ctrl_test;
	import led_fault_pkg::*;
	localparam int unsigned DIMP  = 200;
	localparam int unsigned SCANP = 300;
	logic              pclk, presetn, dim_in, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0]       paddr, pwdata, prdata, rd;
	sense_type         sense;
	adc_type           adc;
	logic [5:0]        sink_on, fb_inc;
	logic [7:0]        level;
	logic signed [3:0] trim;
	logic              conv_on, ss_req, conv_run, low_dim, flag_o, flag_oe;
	logic [1:0]        sthr;
	int                fail_count, n_tests, i, j, lo, hi;

	apb_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	led_driver_fault_monitor_ctrl #(.DIM_PERIOD(DIMP), .SCAN_PERIOD(SCANP)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sense(sense), .adc(adc), .dim_in(dim_in), .sink_on(sink_on), .current_level(level),
		.feedback_include(fb_inc), .freq_trim_pct(trim), .converter_on(conv_on),
		.soft_start_req(ss_req), .conv_run(conv_run), .low_dim(low_dim),
		.short_threshold_sel(sthr), .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		host_u.xfer(1'b1, idx, v, rd, err);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] v);
		host_u.xfer(1'b0, idx, 8'h00, rd, err);
		chk(rd, {24'h0, v});
	endtask

	// saturating code of a raw 9-bit sample
	function automatic logic [7:0] code(input logic [8:0] c);
		return c[8] ? FULL_SCALE : c[7:0];
	endfunction

	// dither window: off gives zero, on stays in the span and really moves
	function automatic logic trim_ok(input int s, input int l, input int h);
		int span;
		span = s[0] ? 6 : 3;
		if (s[1] || s[2]) return l == 0 && h == 0;
		return l >= -span && h <= span && h - l > span;
	endfunction

	// start a conversion and poll the busy bit, bounded
	task automatic convert;
		wr(IDX_FULL_SCALE_CURRENT_SEL, 8'h40);
		i = 0;
		hi = 0;
		do begin
			host_u.xfer(1'b0, IDX_FULL_SCALE_CURRENT_SEL, 8'h00, rd, err);
			hi += conv_run;
			i++;
		end while (rd[FULL_SCALE_CURRENT_SEL_CONVERT] !== 1'b0 && i < 2000);
		chk(i <= 410, 1);
		chk({hi != 0, conv_run}, 2'b10);
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		sense <= '0;
		cyc(2);
		presetn <= 1'b1;
		sense.soft_start_done <= 1'b1;
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		stop_test;
	end

	initial begin
		presetn = 1'b0;
		dim_in = 1'b0;
		sense = '0;
		adc = '0;
		void'($urandom(82707));
		do_reset;
		rdchk(IDX_SETTING, 8'h01);
		rdchk(IDX_MASK, 8'h00);
		rdchk(IDX_DIAG, 8'h00);
		rdchk(IDX_DUTY, 8'h00);
		rdchk(8'h30, 8'h00);
		chk({err, flag_o, sthr}, 4'b1001);
		// s bit0 wide span, bit1 spread off, bit2 external sync
		for (int s = 0; s < 5; s++) begin
			wr(IDX_SETTING, {4'h0, s[1:0], 2'b01});
			sense.ext_sync <= s[2];
			cyc(2);
			lo = 0;
			hi = 0;
			repeat (100) begin
				@(posedge pclk);
				if ($isunknown(trim)) lo = 99;
				if (trim < lo) lo = trim;
				if (trim > hi) hi = trim;
			end
			chk(trim_ok(s, lo, hi), 1);
		end
		sense.ext_sync <= 1'b0;
		dim_in <= 1'b1;
		wr(IDX_SETTING, 8'h01);
		wr(IDX_IMODE, 8'h08);
		cyc(1100);
		chk({low_dim, sink_on, level}, {1'b0, 6'h3f, FULL_SCALE});
		for (j = 0; j < 6; j++) adc.current[j] <= 9'($urandom);
		adc.current[5] <= {1'b1, 8'($urandom)};
		adc.boost <= 8'($urandom);
		convert;
		for (j = 0; j < 6; j++) rdchk(8'(IDX_IOUT1 + j), code(adc.current[j]));
		rdchk(IDX_BOOST_MONITOR, adc.boost);
		sense.short_det <= 6'h04;
		cyc(2 * SCANP + 4);
		chk({flag_oe, sink_on[2]}, 2'b10);
		rdchk(IDX_SHORTLED, 8'h04);
		sense.short_det <= 6'h00;
		cyc(2 * SCANP + 4);
		chk(flag_oe, 0);
		wr(IDX_SETTING, 8'h00);
		sense.short_det <= 6'h04;
		cyc(2 * SCANP + 4);
		chk(flag_oe, 0);
		rdchk(IDX_SHORTLED, 8'h00);
		sense.short_det <= 6'h00;
		sense.below_300mv <= 6'h10;
		cyc(3);
		chk(fb_inc[4], 0);
		sense.below_300mv <= 6'h00;
		sense.temp_hot <= 1'b1;
		cyc(3);
		chk({flag_oe, conv_on}, 2'b10);
		rdchk(IDX_DIAG, 8'h01);
		sense.temp_hot <= 1'b0;
		sense.temp_cool <= 1'b1;
		for (j = 0; j < 20 && ss_req !== 1'b1; j++) begin
			@(posedge pclk);
		end
		chk(j < 20, 1);
		sense.temp_cool <= 1'b0;
		cyc(3);
		chk({flag_oe, conv_on}, 2'b01);
		sense.temp_warn <= 1'b1;
		cyc(3);
		chk(flag_oe, 1);
		rdchk(IDX_DIAG, 8'h02);
		wr(IDX_MASK, 8'h02);
		cyc(2);
		chk(flag_oe, 0);
		sense.temp_warn <= 1'b0;
		// internal dimming at this short period keeps every string in low-dim
		wr(IDX_IMODE, 8'h00);
		wr(IDX_DUTY, 8'h80);
		cyc(2);
		// two whole periods of half duty: sink on for exactly one period's worth
		lo = 0;
		repeat (2 * DIMP) begin
			@(posedge pclk);
			lo += sink_on[0];
		end
		chk(lo, 2 * DIMP * 128 / 256);
		chk(low_dim, 1);
		convert;
		for (j = 0; j < 6; j++) rdchk(8'(IDX_IOUT1 + j), 8'h00);
		// hybrid with threshold select 1: linear above the level, pwm at it below
		wr(IDX_IMODE, 8'h05);
		cyc(2);
		chk({sink_on, level}, {6'h3f, 8'h80});
		wr(IDX_DUTY, 8'h20);
		cyc(2);
		chk(level, HDIM_LEVEL[1]);
		sense.boost_uv <= 1'b1;
		cyc(3);
		chk(flag_oe, 1);
		rdchk(IDX_DIAG, 8'h10);
		sense.boost_uv <= 1'b0;
		sense.open_det <= 6'h02;
		cyc(3);
		chk(fb_inc[1], 0);
		rdchk(IDX_OPEN, 8'h02);
		sense.open_det <= 6'h00;
		cyc(3);
		chk(flag_oe, 1);
		sense.open_det <= 6'h02;
		sense.boost_ov <= 1'b1;
		cyc(3);
		chk({flag_oe, conv_on}, 2'b10);
		do_reset;
		cyc(2);
		chk({flag_oe, conv_on, host_u.hung}, 3'b010);
		stop_test;
	end
endmodule
